// file: verilog/cpu_flags_defs.vh
`ifndef CPU_FLAGS_DEFS_VH
`define CPU_FLAGS_DEFS_VH

// Register byte offsets on APB
`define OFS_COMMAND 8'h00
`define OFS_OPERAND 8'h04
`define OFS_MAIN_AF 8'h08
`define OFS_MAIN_BC 8'h0C
`define OFS_MAIN_DE 8'h10
`define OFS_MAIN_HL 8'h14
`define OFS_ALT_AF 8'h18
`define OFS_ALT_BC 8'h1C
`define OFS_ALT_DE 8'h20
`define OFS_ALT_HL 8'h24
`define OFS_VECTOR 8'h28
`define OFS_REFRESH 8'h2C
`define OFS_ISR_PTR 8'h30

// Command register fields and the vector register enable bit
`define CMD_OP_MSB 4
`define CMD_BIT_LSB 8
`define CMD_BIT_MSB 10
`define CMD_DIR_BIT 12
`define VEC_IFF_BIT 8

// Flag byte positions
`define FLAG_C 0
`define FLAG_N 1
`define FLAG_PV 2
`define FLAG_H 4
`define FLAG_Z 6
`define FLAG_S 7
`define FLAG_USED_MASK 8'hD7

// Bank slot indices
`define SLOT_B 3'h0
`define SLOT_C 3'h1
`define SLOT_D 3'h2
`define SLOT_E 3'h3
`define SLOT_H 3'h4
`define SLOT_L 3'h5
`define SLOT_F 3'h6
`define SLOT_A 3'h7

// Operation codes
`define OP_NOP 5'h00
`define OP_ADD 5'h01
`define OP_ADC 5'h02
`define OP_SUB 5'h03
`define OP_SBC 5'h04
`define OP_CMP 5'h05
`define OP_AND 5'h06
`define OP_OR 5'h07
`define OP_XOR 5'h08
`define OP_RLC 5'h09
`define OP_RRC 5'h0A
`define OP_RL 5'h0B
`define OP_RR 5'h0C
`define OP_SLA 5'h0D
`define OP_SRA 5'h0E
`define OP_SRL 5'h0F
`define OP_DAA 5'h10
`define OP_SCF 5'h11
`define OP_CCF 5'h12
`define OP_BIT 5'h13
`define OP_IN 5'h14
`define OP_LD_A_VEC 5'h15
`define OP_LD_A_REF 5'h16
`define OP_BLK_MOVE 5'h17
`define OP_BLK_CMP 5'h18
`define OP_BLK_IO 5'h19
`define OP_EXX 5'h1A
`define OP_EX_AF 5'h1B

// Reset values
`define RST_BYTE 8'h00
`define RST_REFRESH 7'h00

`endif

// file: verilog/flag_unit.v
`timescale 1ns/100ps
`default_nettype none
`include "cpu_flags_defs.vh"

module flag_unit (
  // Operation
  input wire [4:0] op,
  input wire [2:0] bit_sel,
  // Operands
  input wire [7:0] acc,
  input wire [7:0] operand,
  input wire [7:0] flags_in,
  input wire [7:0] vec,
  input wire [6:0] refresh,
  input wire interrupt_enable_copy,
  input wire [15:0] count_next,
  // Results
  output reg [7:0] result,
  output reg [7:0] flags_out,
  output reg acc_we
);

  function parity_even;
    input [7:0] v;
    begin
      parity_even = ~^v;
    end
  endfunction

  reg [8:0] wide;
  reg [4:0] nib;
  reg cin;
  reg [7:0] corr;
  reg cout;

  always @* begin
    wide = 9'h000;
    nib = 5'h00;
    corr = 8'h00;
    cout = flags_in[`FLAG_C];
    cin = ((op == `OP_ADC) || (op == `OP_SBC)) ? flags_in[`FLAG_C] : 1'b0;
    result = acc;
    flags_out = flags_in;
    acc_we = 1'b0;
    case (op)
      `OP_ADD, `OP_ADC: begin
        wide = {1'b0, acc} + {1'b0, operand} + {8'h00, cin};
        nib = {1'b0, acc[3:0]} + {1'b0, operand[3:0]} + {4'h0, cin};
        result = wide[7:0];
        acc_we = 1'b1;
        flags_out[`FLAG_C] = wide[8];
        flags_out[`FLAG_N] = 1'b0;
        flags_out[`FLAG_H] = nib[4];
        flags_out[`FLAG_PV] = (acc[7] == operand[7]) && (wide[7] != acc[7]);
      end
      `OP_SUB, `OP_SBC, `OP_CMP, `OP_BLK_CMP: begin
        wide = {1'b0, acc} - {1'b0, operand} - {8'h00, cin};
        nib = {1'b0, acc[3:0]} - {1'b0, operand[3:0]} - {4'h0, cin};
        result = wide[7:0];
        acc_we = (op == `OP_SUB) || (op == `OP_SBC);
        flags_out[`FLAG_N] = 1'b1;
        flags_out[`FLAG_H] = nib[4];
        if (op == `OP_BLK_CMP) begin
          flags_out[`FLAG_PV] = (count_next != 16'h0000);
        end else begin
          flags_out[`FLAG_C] = wide[8];
          // Same-sign subtraction can never overflow
          flags_out[`FLAG_PV] = (acc[7] != operand[7]) && (wide[7] != acc[7]);
        end
      end
      `OP_AND, `OP_OR, `OP_XOR: begin
        result = (op == `OP_AND) ? (acc & operand) : (op == `OP_OR) ? (acc | operand) : (acc ^ operand);
        acc_we = 1'b1;
        flags_out[`FLAG_C] = 1'b0;
        flags_out[`FLAG_N] = 1'b0;
        flags_out[`FLAG_H] = 1'b0;
        flags_out[`FLAG_PV] = parity_even(result);
      end
      `OP_RLC, `OP_RRC, `OP_RL, `OP_RR, `OP_SLA, `OP_SRA, `OP_SRL: begin
        case (op)
          `OP_RLC: result = {acc[6:0], acc[7]};
          `OP_RRC: result = {acc[0], acc[7:1]};
          `OP_RL: result = {acc[6:0], flags_in[`FLAG_C]};
          `OP_RR: result = {flags_in[`FLAG_C], acc[7:1]};
          `OP_SLA: result = {acc[6:0], 1'b0};
          `OP_SRA: result = {acc[7], acc[7:1]};
          default: result = {1'b0, acc[7:1]};
        endcase
        acc_we = 1'b1;
        if ((op == `OP_RLC) || (op == `OP_RL) || (op == `OP_SLA)) begin
          flags_out[`FLAG_C] = acc[7];
        end else begin
          flags_out[`FLAG_C] = acc[0];
        end
        flags_out[`FLAG_N] = 1'b0;
        flags_out[`FLAG_H] = 1'b0;
        flags_out[`FLAG_PV] = parity_even(result);
      end
      `OP_DAA: begin
        if (flags_in[`FLAG_H] || (!flags_in[`FLAG_N] && (acc[3:0] > 4'h9))) begin
          corr[3:0] = 4'h6;
        end
        if (flags_in[`FLAG_C] || (!flags_in[`FLAG_N] && (acc > 8'h99))) begin
          corr[7:4] = 4'h6;
          cout = 1'b1;
        end
        result = flags_in[`FLAG_N] ? (acc - corr) : (acc + corr);
        acc_we = 1'b1;
        flags_out[`FLAG_C] = cout;
        flags_out[`FLAG_H] = flags_in[`FLAG_N] ? (flags_in[`FLAG_H] && (acc[3:0] < 4'h6)) : (acc[3:0] > 4'h9);
        flags_out[`FLAG_PV] = parity_even(result);
      end
      `OP_SCF, `OP_CCF: begin
        flags_out[`FLAG_C] = (op == `OP_SCF);
        flags_out[`FLAG_N] = 1'b0;
        flags_out[`FLAG_H] = 1'b0;
      end
      `OP_BIT: begin
        flags_out[`FLAG_Z] = ~operand[bit_sel];
        flags_out[`FLAG_H] = 1'b1;
        flags_out[`FLAG_N] = 1'b0;
      end
      `OP_IN: begin
        result = operand;
        acc_we = 1'b1;
        flags_out[`FLAG_PV] = parity_even(operand);
        flags_out[`FLAG_H] = 1'b0;
        flags_out[`FLAG_N] = 1'b0;
      end
      `OP_LD_A_VEC, `OP_LD_A_REF: begin
        result = (op == `OP_LD_A_VEC) ? vec : {1'b0, refresh};
        acc_we = 1'b1;
        flags_out[`FLAG_PV] = interrupt_enable_copy;
        flags_out[`FLAG_H] = 1'b0;
        flags_out[`FLAG_N] = 1'b0;
      end
      `OP_BLK_MOVE: begin
        flags_out[`FLAG_PV] = (count_next != 16'h0000);
        flags_out[`FLAG_H] = 1'b0;
        flags_out[`FLAG_N] = 1'b0;
      end
      `OP_BLK_IO: begin
        flags_out[`FLAG_Z] = (count_next[15:8] == 8'h00);
        flags_out[`FLAG_N] = 1'b1;
      end
      default: begin
        flags_out = flags_in;
      end
    endcase
    // Sign and zero follow the byte produced by the operation
    if (acc_we || (op == `OP_CMP) || (op == `OP_BLK_CMP)) begin
      flags_out[`FLAG_S] = result[7];
      flags_out[`FLAG_Z] = (result == 8'h00);
    end
    flags_out = flags_out & `FLAG_USED_MASK;
  end

endmodule

`default_nettype wire

// file: verilog/cpu_flag_regs.v
// How it works
// - Carry set on add carry or subtract borrow
// - Decimal adjust sets carry when correcting high
// - Through-carry rotates loop carry as ninth bit
// - Left circular rotate, arith shift: bit7 to carry
// - Right rotates and shifts move bit0 to carry
// - AND, OR, XOR clear carry
// - Set-carry forces one, complement-carry clears it
// - Add clears subtract flag, subtract sets it
// - Signed overflow sets parity/overflow flag
// - Same-sign subtraction clears parity/overflow
// - Logic and rotates give even parity flag
// - Block move and search: flag set while counter nonzero
// - Vector/refresh loads copy interrupt enable copy
// - Port input sets parity, zero, sign
// - Half-carry from nibble carry or borrow
// - Zero flag on zero arithmetic/logic result
// - Block search sets zero on match
// - Bit test writes inverted bit to zero
// - Block input/output: zero when B-1 zero
// - Sign flag copies result bit seven
// - Main and alternate banks, exchange swaps them
// - Service pointer is vector byte then device byte
`timescale 1ns/100ps
`default_nettype none
`include "cpu_flags_defs.vh"

module cpu_flag_regs (
  // APB clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Interrupt acknowledge from the core, same clock
  input wire int_ack,
  input wire [7:0] int_vec_low,
  // Status toward the core
  output reg [15:0] isr_pointer,
  output reg [7:0] flag_byte,
  output reg [6:0] refresh_addr
);

  // Bank slots B C D E H L F A
  reg [7:0] main_q [0:7];
  reg [7:0] alt_q [0:7];
  reg [7:0] operand_q;
  reg [7:0] vector_q;
  reg interrupt_enable_copy_q;
  reg [6:0] refresh_q;
  reg [12:0] command_q;
  reg exec_q;

  wire setup = psel && !penable;
  wire do_write = psel && penable && pready && pwrite;
  wire [4:0] cmd_op = command_q[`CMD_OP_MSB:0];
  wire [2:0] cmd_bit = command_q[`CMD_BIT_MSB:`CMD_BIT_LSB];
  wire cmd_dir = command_q[`CMD_DIR_BIT];

  function [15:0] pair;
    input [7:0] hi;
    input [7:0] lo;
    begin
      pair = {hi, lo};
    end
  endfunction

  function mapped;
    input [7:0] a;
    begin
      mapped = (a[1:0] == 2'b00) && (a <= `OFS_ISR_PTR);
    end
  endfunction

  wire [15:0] bc = pair(main_q[`SLOT_B], main_q[`SLOT_C]);
  wire [15:0] hl = pair(main_q[`SLOT_H], main_q[`SLOT_L]);
  wire [15:0] de = pair(main_q[`SLOT_D], main_q[`SLOT_E]);
  wire [15:0] bc_dec = bc - 16'h0001;
  wire [15:0] hl_step = cmd_dir ? (hl - 16'h0001) : (hl + 16'h0001);
  wire [15:0] de_step = cmd_dir ? (de - 16'h0001) : (de + 16'h0001);
  wire [7:0] b_dec = main_q[`SLOT_B] - 8'h01;
  // Block input/output counts in B alone, the others in the whole pair
  wire [15:0] count_next = (cmd_op == `OP_BLK_IO) ? {b_dec, main_q[`SLOT_C]} : bc_dec;

  wire [7:0] fu_result;
  wire [7:0] fu_flags;
  wire fu_acc_we;

  flag_unit u_flag_unit (
    .op(cmd_op),
    .bit_sel(cmd_bit),
    .acc(main_q[`SLOT_A]),
    .operand(operand_q),
    .flags_in(main_q[`SLOT_F]),
    .vec(vector_q),
    .refresh(refresh_q),
    .interrupt_enable_copy(interrupt_enable_copy_q),
    .count_next(count_next),
    .result(fu_result),
    .flags_out(fu_flags),
    .acc_we(fu_acc_we)
  );

  // APB handshake: ready rises for the access phase, one wait-free access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped(paddr);
    end
  end

  // Read data captured in the setup cycle, stable through the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      case (paddr)
        `OFS_COMMAND: prdata <= {19'h00000, command_q};
        `OFS_OPERAND: prdata <= {24'h000000, operand_q};
        `OFS_MAIN_AF: prdata <= {16'h0000, main_q[`SLOT_A], main_q[`SLOT_F]};
        `OFS_MAIN_BC: prdata <= {16'h0000, bc};
        `OFS_MAIN_DE: prdata <= {16'h0000, de};
        `OFS_MAIN_HL: prdata <= {16'h0000, hl};
        `OFS_ALT_AF: prdata <= {16'h0000, alt_q[`SLOT_A], alt_q[`SLOT_F]};
        `OFS_ALT_BC: prdata <= {16'h0000, alt_q[`SLOT_B], alt_q[`SLOT_C]};
        `OFS_ALT_DE: prdata <= {16'h0000, alt_q[`SLOT_D], alt_q[`SLOT_E]};
        `OFS_ALT_HL: prdata <= {16'h0000, alt_q[`SLOT_H], alt_q[`SLOT_L]};
        `OFS_VECTOR: prdata <= {23'h000000, interrupt_enable_copy_q, vector_q};
        `OFS_REFRESH: prdata <= {25'h0000000, refresh_q};
        `OFS_ISR_PTR: prdata <= {16'h0000, isr_pointer};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Command, operand, vector and interrupt enable copy
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      command_q <= 13'h0000;
      operand_q <= `RST_BYTE;
      vector_q <= `RST_BYTE;
      interrupt_enable_copy_q <= 1'b0;
      exec_q <= 1'b0;
    end else begin
      // Execution runs in the cycle after the command write lands
      exec_q <= do_write && (paddr == `OFS_COMMAND);
      if (do_write) begin
        case (paddr)
          `OFS_COMMAND: command_q <= pwdata[12:0];
          `OFS_OPERAND: operand_q <= pwdata[7:0];
          `OFS_VECTOR: begin
            vector_q <= pwdata[7:0];
            interrupt_enable_copy_q <= pwdata[`VEC_IFF_BIT];
          end
          default: operand_q <= operand_q;
        endcase
      end
    end
  end

  // Refresh counter steps once per executed operation, seven bits wide
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refresh_q <= `RST_REFRESH;
    end else if (exec_q) begin
      refresh_q <= refresh_q + 7'h01;
    end
  end

  // Interrupt pointer: vector on top, device byte below
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      isr_pointer <= 16'h0000;
    end else if (int_ack) begin
      isr_pointer <= {vector_q, int_vec_low};
    end
  end

  // Register banks; software writes and execution never meet in one cycle
  // because an APB write needs a setup cycle after the command write
  integer i;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < 8; i = i + 1) begin
        main_q[i] <= `RST_BYTE;
        alt_q[i] <= `RST_BYTE;
      end
    end else if (exec_q) begin
      case (cmd_op)
        `OP_EXX: begin
          for (i = 0; i < 6; i = i + 1) begin
            main_q[i] <= alt_q[i];
            alt_q[i] <= main_q[i];
          end
        end
        `OP_EX_AF: begin
          main_q[`SLOT_A] <= alt_q[`SLOT_A];
          main_q[`SLOT_F] <= alt_q[`SLOT_F];
          alt_q[`SLOT_A] <= main_q[`SLOT_A];
          alt_q[`SLOT_F] <= main_q[`SLOT_F];
        end
        `OP_BLK_MOVE, `OP_BLK_CMP: begin
          main_q[`SLOT_F] <= fu_flags;
          main_q[`SLOT_B] <= bc_dec[15:8];
          main_q[`SLOT_C] <= bc_dec[7:0];
          main_q[`SLOT_H] <= hl_step[15:8];
          main_q[`SLOT_L] <= hl_step[7:0];
          if (cmd_op == `OP_BLK_MOVE) begin
            main_q[`SLOT_D] <= de_step[15:8];
            main_q[`SLOT_E] <= de_step[7:0];
          end
        end
        `OP_BLK_IO: begin
          main_q[`SLOT_F] <= fu_flags;
          main_q[`SLOT_B] <= b_dec;
          main_q[`SLOT_H] <= hl_step[15:8];
          main_q[`SLOT_L] <= hl_step[7:0];
        end
        default: begin
          main_q[`SLOT_F] <= fu_flags;
          if (fu_acc_we) begin
            main_q[`SLOT_A] <= fu_result;
          end
        end
      endcase
    end else if (do_write) begin
      case (paddr)
        `OFS_MAIN_AF: begin
          main_q[`SLOT_A] <= pwdata[15:8];
          main_q[`SLOT_F] <= pwdata[7:0] & `FLAG_USED_MASK;
        end
        `OFS_MAIN_BC: begin
          main_q[`SLOT_B] <= pwdata[15:8];
          main_q[`SLOT_C] <= pwdata[7:0];
        end
        `OFS_MAIN_DE: begin
          main_q[`SLOT_D] <= pwdata[15:8];
          main_q[`SLOT_E] <= pwdata[7:0];
        end
        `OFS_MAIN_HL: begin
          main_q[`SLOT_H] <= pwdata[15:8];
          main_q[`SLOT_L] <= pwdata[7:0];
        end
        `OFS_ALT_AF: begin
          alt_q[`SLOT_A] <= pwdata[15:8];
          alt_q[`SLOT_F] <= pwdata[7:0] & `FLAG_USED_MASK;
        end
        `OFS_ALT_BC: begin
          alt_q[`SLOT_B] <= pwdata[15:8];
          alt_q[`SLOT_C] <= pwdata[7:0];
        end
        `OFS_ALT_DE: begin
          alt_q[`SLOT_D] <= pwdata[15:8];
          alt_q[`SLOT_E] <= pwdata[7:0];
        end
        `OFS_ALT_HL: begin
          alt_q[`SLOT_H] <= pwdata[15:8];
          alt_q[`SLOT_L] <= pwdata[7:0];
        end
        default: begin
          alt_q[`SLOT_A] <= alt_q[`SLOT_A];
        end
      endcase
    end
  end

  // Mirrors toward the core, one cycle behind the bank
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_byte <= `RST_BYTE;
      refresh_addr <= `RST_REFRESH;
    end else begin
      flag_byte <= main_q[`SLOT_F];
      refresh_addr <= refresh_q;
    end
  end

endmodule

`default_nettype wire

// file: test/cpu_flag_regs_properties.sv
`timescale 1ns/100ps
`default_nettype none
module cpu_flag_regs_properties (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Interrupt and status
  input wire logic int_ack,
  input wire logic [7:0] int_vec_low,
  input wire logic [15:0] isr_pointer,
  input wire logic [7:0] flag_byte,
  input wire logic [6:0] refresh_addr
);
  // Decoded from the bus only, so a wrong decode inside the design shows up
  wire setup = psel && !penable;
  wire map_ok = (paddr[1:0] == 2'b00) && (paddr <= 8'h30);
  wire cmd_wr = pready && psel && penable && pwrite && (paddr == 8'h00);

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_after_setup: assert property (setup |=> pready)
    else $error("ready missing after setup");
  a_ready_in_access: assert property (pready |-> psel && penable && $past(setup))
    else $error("ready outside access phase");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_unmapped_error: assert property (pready && !map_ok |-> pslverr)
    else $error("unmapped access without error");
  a_mapped_okay: assert property (pready && map_ok |-> !pslverr)
    else $error("error on mapped access");
  a_error_data_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("read data on error not zero");
  a_isr_capture: assert property (int_ack |=> isr_pointer[7:0] == $past(int_vec_low))
    else $error("pointer low byte not captured");
  a_isr_hold: assert property (!int_ack |=> $stable(isr_pointer))
    else $error("pointer changed without acknowledge");
  a_flag_unused_bits: assert property (flag_byte[5] == 1'b0 && flag_byte[3] == 1'b0)
    else $error("unused flag bits set");
  // Command taken at E, executed at E+1, mirror updated at E+2
  a_refresh_step: assert property (cmd_wr |-> ##3 refresh_addr == $past(refresh_addr, 3) + 7'h01)
    else $error("refresh did not step once per command");
endmodule

bind cpu_flag_regs cpu_flag_regs_properties u_cpu_flag_regs_properties (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .int_ack(int_ack),
  .int_vec_low(int_vec_low),
  .isr_pointer(isr_pointer),
  .flag_byte(flag_byte),
  .refresh_addr(refresh_addr)
);
`default_nettype wire

// file: test/test_cpu_flag_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "cpu_flags_defs.vh"
module test_cpu_flag_regs;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic int_ack = 1'b0;
  logic [7:0] int_vec_low = 8'h00;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire [15:0] isr_pointer;
  wire [7:0] flag_byte;
  wire [6:0] refresh_addr;
  logic [31:0] rq;
  logic rerr;
  logic dir = 1'b0;
  logic [2:0] sel = 3'h0;
  int n_cmd = 0;
  int n_mismatch = 0;
  int check_count = 0;
  localparam logic [7:0] af = `OFS_MAIN_AF;
  localparam logic [7:0] bc = `OFS_MAIN_BC;
  localparam logic [7:0] vec = `OFS_VECTOR;

  always #4 pclk = ~pclk;

  cpu_flag_regs u_cpu_flag_regs (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .int_ack(int_ack),
    .int_vec_low(int_vec_low),
    .isr_pointer(isr_pointer),
    .flag_byte(flag_byte),
    .refresh_addr(refresh_addr)
  );

  task results;
    begin
      $display("Checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      check_count++;
      if (got !== exp) begin
        n_mismatch++;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // Entered just after an edge; the idle edge at the end keeps psel from being driven twice in one step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Answer is read mid-cycle, where it has settled, then the sampling edge passes
      @(negedge pclk);
      while (pready !== 1'b1) @(negedge pclk);
      rq = prdata;
      rerr = pslverr;
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask

  task rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      chk(rq & m, e);
    end
  endtask

  task cmd(input logic [4:0] op);
    begin
      apb(1'b1, `OFS_COMMAND, {19'h0, dir, 1'b0, sel, 3'h0, op});
      n_cmd++;
    end
  endtask

  task alu(input logic [4:0] op, input logic [7:0] a, f, d, ea, ef, m);
    begin
      apb(1'b1, `OFS_OPERAND, {24'h0, d});
      apb(1'b1, af, {16'h0, a, f});
      cmd(op);
      rchk(af, {16'h0, 8'hFF, m}, {16'h0, ea, ef & m});
      chk({24'h0, flag_byte & m}, {24'h0, ef & m});
    end
  endtask

  task t_reset;
    begin
      for (int i = 0; i <= 48; i += 4) begin
        rchk(i[7:0], 32'hFFFFFFFF, 32'h0);
      end
      chk({isr_pointer, flag_byte, 1'b0, refresh_addr}, 32'h0);
    end
  endtask

  task t_arith;
    begin
      alu(5'h01, 8'h78, 8'h00, 8'h69, 8'hE1, 8'h94, 8'hD7);
      alu(5'h01, 8'hFF, 8'h00, 8'h01, 8'h00, 8'h51, 8'hD7);
      alu(5'h02, 8'h0F, 8'h01, 8'h00, 8'h10, 8'h10, 8'hD7);
      alu(5'h03, 8'h7F, 8'h00, 8'hC0, 8'hBF, 8'h87, 8'hD7);
      alu(5'h03, 8'h10, 8'h00, 8'h01, 8'h0F, 8'h12, 8'hD7);
      alu(5'h04, 8'h00, 8'h01, 8'h00, 8'hFF, 8'h93, 8'hD7);
      alu(5'h05, 8'h55, 8'h00, 8'h55, 8'h55, 8'h42, 8'hD7);
    end
  endtask

  task t_logic;
    begin
      alu(5'h06, 8'hF0, 8'h01, 8'h3C, 8'h30, 8'h04, 8'hC5);
      alu(5'h07, 8'h00, 8'h01, 8'h00, 8'h00, 8'h44, 8'hC5);
      alu(5'h08, 8'h81, 8'h01, 8'h01, 8'h80, 8'h80, 8'hC5);
      alu(5'h09, 8'h81, 8'h00, 8'h00, 8'h03, 8'h05, 8'h05);
      alu(5'h0A, 8'h01, 8'h00, 8'h00, 8'h80, 8'h01, 8'h05);
      alu(5'h0B, 8'h80, 8'h01, 8'h00, 8'h01, 8'h01, 8'h05);
      alu(5'h0C, 8'h01, 8'h01, 8'h00, 8'h80, 8'h01, 8'h05);
      alu(5'h0D, 8'h80, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01);
      alu(5'h0E, 8'h81, 8'h00, 8'h00, 8'hC0, 8'h01, 8'h01);
      alu(5'h0F, 8'h81, 8'h00, 8'h00, 8'h40, 8'h01, 8'h01);
    end
  endtask

  task t_misc;
    begin
      alu(5'h00, 8'h12, 8'h81, 8'h00, 8'h12, 8'h81, 8'hD7);
      alu(5'h1F, 8'h12, 8'h81, 8'h00, 8'h12, 8'h81, 8'hD7);
      alu(5'h10, 8'h9A, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01);
      alu(5'h11, 8'h12, 8'h00, 8'h00, 8'h12, 8'h01, 8'h01);
      alu(5'h12, 8'h12, 8'h01, 8'h00, 8'h12, 8'h00, 8'h01);
      sel = 3'h3;
      alu(5'h13, 8'h12, 8'h00, 8'h08, 8'h12, 8'h00, 8'h40);
      sel = 3'h4;
      alu(5'h13, 8'h12, 8'h00, 8'h08, 8'h12, 8'h40, 8'h40);
      sel = 3'h0;
      alu(5'h14, 8'h12, 8'h00, 8'h00, 8'h00, 8'h44, 8'hC4);
      alu(5'h14, 8'h12, 8'h00, 8'h83, 8'h83, 8'h80, 8'hC4);
      apb(1'b1, vec, 32'h1AB);
      alu(5'h15, 8'h00, 8'h00, 8'h00, 8'hAB, 8'h04, 8'h04);
      apb(1'b1, vec, 32'h0AB);
      alu(5'h15, 8'h00, 8'h04, 8'h00, 8'hAB, 8'h00, 8'h04);
      // Read-only: the write must be ignored
      apb(1'b1, `OFS_REFRESH, 32'h55);
      rchk(`OFS_REFRESH, 32'hFFFFFFFF, {25'h0, n_cmd[6:0]});
      apb(1'b1, vec, 32'h100);
      alu(5'h16, 8'h00, 8'h00, 8'h00, {1'b0, n_cmd[6:0]}, 8'h04, 8'h04);
    end
  endtask

  task t_block;
    begin
      apb(1'b1, bc, 32'h0001);
      apb(1'b1, `OFS_MAIN_DE, 32'h2000);
      apb(1'b1, `OFS_MAIN_HL, 32'h1000);
      cmd(5'h17);
      rchk(af, 32'h4, 32'h0);
      rchk(bc, 32'hFFFF, 32'h0000);
      apb(1'b1, bc, 32'h0002);
      dir = 1'b1;
      cmd(5'h17);
      rchk(af, 32'h4, 32'h4);
      rchk(`OFS_MAIN_HL, 32'hFFFF, 32'h1000);
      apb(1'b1, bc, 32'h0001);
      apb(1'b1, af, 32'h5500);
      apb(1'b1, `OFS_OPERAND, 32'h55);
      cmd(5'h18);
      rchk(af, 32'hFF44, 32'h5540);
      apb(1'b1, bc, 32'h0003);
      apb(1'b1, `OFS_OPERAND, 32'h54);
      cmd(5'h18);
      rchk(af, 32'hFF44, 32'h5504);
      dir = 1'b0;
      apb(1'b1, bc, 32'h0105);
      cmd(5'h19);
      rchk(af, 32'h40, 32'h40);
      rchk(bc, 32'hFFFF, 32'h0005);
      apb(1'b1, bc, 32'h0205);
      cmd(5'h19);
      rchk(af, 32'h40, 32'h00);
    end
  endtask

  task t_bank;
    begin
      for (int i = 0; i < 3; i++) begin
        apb(1'b1, 8'(bc + 4 * i), 32'h1111 * (i + 1));
        apb(1'b1, 8'(`OFS_ALT_BC + 4 * i), 32'h1111 * (i + 5));
      end
      apb(1'b1, af, 32'h4455);
      apb(1'b1, `OFS_ALT_AF, 32'h9981);
      cmd(5'h1A);
      for (int i = 0; i < 3; i++) begin
        rchk(8'(bc + 4 * i), 32'hFFFF, 32'h1111 * (i + 5));
        rchk(8'(`OFS_ALT_BC + 4 * i), 32'hFFFF, 32'h1111 * (i + 1));
      end
      rchk(af, 32'hFFFF, 32'h4455);
      cmd(5'h1B);
      rchk(af, 32'hFFFF, 32'h9981);
      rchk(`OFS_ALT_AF, 32'hFFFF, 32'h4455);
    end
  endtask

  task t_isr;
    begin
      apb(1'b1, vec, 32'h12);
      int_ack <= 1'b1;
      int_vec_low <= 8'h34;
      @(posedge pclk);
      int_ack <= 1'b0;
      // A late capture would pick up this value instead
      int_vec_low <= 8'hCB;
      @(posedge pclk);
      chk({16'h0, isr_pointer}, 32'h1234);
      rchk(`OFS_ISR_PTR, 32'hFFFF, 32'h1234);
    end
  endtask

  task t_bus;
    begin
      apb(1'b0, 8'h34, 32'h0);
      chk({rerr, rq[30:0]}, 32'h80000000);
      apb(1'b1, 8'h02, 32'hFFFF);
      chk({31'h0, rerr}, 32'h1);
      apb(1'b1, af, 32'h00FF);
      rchk(af, 32'hFFFF, 32'h00D7);
      chk({31'h0, rerr}, 32'h0);
    end
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_arith;
    t_logic;
    t_misc;
    t_block;
    t_bank;
    t_isr;
    t_bus;
    results;
  end

  // The sequence needs well under 2000 cycles; ten times that means a hang
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    results;
  end
endmodule
`default_nettype wire
